// ===== src/adc_seq_pkg.sv
package adc_seq_pkg;

    // ==========================================================
    // conversion geometry
    localparam int RESULT_WIDTH      = 10;
    localparam int CONV_STATES_LONG  = 62;
    localparam int CONV_STATES_SHORT = 31;
    localparam int CNT_WIDTH         = 6;
    localparam int RES_HIGH_WIDTH    = 8;
    localparam int RES_LOW_WIDTH     = 2;

    // ==========================================================
    // register map, byte addresses
    localparam int          ADDR_WIDTH     = 5;
    localparam logic [4:0]  OFF_MODE       = 5'h00;
    localparam logic [4:0]  OFF_START      = 5'h04;
    localparam logic [4:0]  OFF_RES_HIGH   = 5'h08;
    localparam logic [4:0]  OFF_RES_LOW    = 5'h0C;
    localparam logic [4:0]  OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0]  OFF_IRQ_CLEAR  = 5'h14;
    localparam logic [4:0]  OFF_IRQ_ENABLE = 5'h18;
    localparam logic [4:0]  OFF_CLK_STOP   = 5'h1C;

    // ==========================================================
    // field positions and fixed values
    localparam int          MODE_TIME_BIT    = 7;
    localparam int          START_FLAG_BIT   = 7;
    localparam int          DONE_BIT         = 0;
    localparam int          CLK_RUN_BIT      = 0;
    localparam int          CH_WIDTH         = 4;
    localparam int          RES_LOW_SHIFT    = 6;
    localparam logic [7:0]  MODE_FIXED_ONES  = 8'h30;
    localparam logic [6:0]  START_FIXED_ONES = 7'h7F;
    localparam logic [1:0]  CH_ACTIVE_PREFIX = 2'h1;
    localparam logic        CLK_RUN_RESET    = 1'h1;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avs_req_s;

    typedef struct packed {
        logic                    sample;
        logic                    chan_en;
        logic [1:0]              chan;
        logic [RESULT_WIDTH-1:0] trial;
    } analog_ctrl_s;

    typedef enum logic [1:0] {
        SAR_IDLE   = 2'h0,
        SAR_SAMPLE = 2'h1,
        SAR_DECIDE = 2'h3
    } sar_state_e;

endpackage : adc_seq_pkg

// ===== src/sar_engine.sv
`timescale 1ns/1ns
module sar_engine #(
    parameter int WIDTH = adc_seq_pkg::RESULT_WIDTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             long_mode,
    // comparator
    input  wire logic             comp,
    // results
    output logic                  sample_reg,
    output logic [WIDTH-1:0]      code_reg,
    output logic [WIDTH-1:0]      result_reg,
    output logic                  done_reg,
    output logic                  busy
);
    localparam int CW = adc_seq_pkg::CNT_WIDTH;
    localparam logic [CW-1:0] LEN_LONG  =
        CW'(adc_seq_pkg::CONV_STATES_LONG);
    localparam logic [CW-1:0] LEN_SHORT =
        CW'(adc_seq_pkg::CONV_STATES_SHORT);
    localparam logic [WIDTH-1:0] TOP_BIT = {1'b1, {(WIDTH-1){1'b0}}};

    adc_seq_pkg::sar_state_e state_reg;
    logic [CW-1:0]           cnt_reg;
    logic [CW-1:0]           elapsed_reg;
    logic [WIDTH-1:0]        mask_reg;
    logic                    long_reg;
    logic [CW-1:0]           conv_len;
    logic [CW-1:0]           samp_last;
    logic [WIDTH-1:0]        kept;

    assign busy      = state_reg != adc_seq_pkg::SAR_IDLE;
    assign conv_len  = long_reg ? LEN_LONG : LEN_SHORT;
    assign samp_last = conv_len - CW'(WIDTH) - CW'(1);
    assign kept      = comp ? code_reg : (code_reg & ~mask_reg);

    // ==========================================================
    // sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= adc_seq_pkg::SAR_IDLE;
        end else if (abort) begin
            state_reg <= adc_seq_pkg::SAR_IDLE;
        end else begin
            unique case (state_reg)
                adc_seq_pkg::SAR_IDLE: begin
                    if (start) state_reg <= adc_seq_pkg::SAR_SAMPLE;
                end
                adc_seq_pkg::SAR_SAMPLE: begin
                    if (cnt_reg == samp_last)
                        state_reg <= adc_seq_pkg::SAR_DECIDE;
                end
                adc_seq_pkg::SAR_DECIDE: begin
                    if (mask_reg[0]) state_reg <= adc_seq_pkg::SAR_IDLE;
                end
                default: state_reg <= adc_seq_pkg::SAR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg     <= '0;
            elapsed_reg <= '0;
            long_reg    <= 1'b0;
            sample_reg  <= 1'b0;
        end else begin
            elapsed_reg <= busy ? elapsed_reg + CW'(1) : '0;
            if (!busy && start) begin
                long_reg   <= long_mode;
                cnt_reg    <= '0;
                sample_reg <= !abort;
            end else begin
                cnt_reg    <= cnt_reg + CW'(1);
                if (abort || cnt_reg == samp_last) sample_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // successive approximation, msb first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_reg   <= '0;
            mask_reg   <= '0;
            result_reg <= '0;
            done_reg   <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg == adc_seq_pkg::SAR_SAMPLE) begin
                code_reg <= TOP_BIT;
                mask_reg <= TOP_BIT;
            end else if (state_reg == adc_seq_pkg::SAR_DECIDE) begin
                code_reg <= kept | (mask_reg >> 1);
                mask_reg <= mask_reg >> 1;
                if (mask_reg[0]) begin
                    result_reg <= kept;
                    done_reg   <= !abort;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_one_bit_per_state;
        state_reg == adc_seq_pkg::SAR_DECIDE |-> $onehot(mask_reg);
    endproperty
    a_one_bit_per_state: assert property (p_one_bit_per_state)
        else $error("decision mask not one-hot");

    property p_start_samples;
        !busy && start && !abort |=> sample_reg &&
            state_reg == adc_seq_pkg::SAR_SAMPLE;
    endproperty
    a_start_samples: assert property (p_start_samples)
        else $error("start did not enter sampling");

    property p_conv_length;
        done_reg |-> elapsed_reg == (long_reg ? LEN_LONG : LEN_SHORT);
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion length wrong");

endmodule : sar_engine

// ===== src/adc_conversion_sequencer.sv
`timescale 1ns/1ns
module adc_conversion_sequencer (
    // clock and reset
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST_N,
    // system state
    input  wire logic                    SOFT_RESET,
    input  wire logic                    LOW_POWER,
    // register bus
    input  wire adc_seq_pkg::avs_req_s   AVS_REQ,
    output logic [31:0]                  AVS_READDATA,
    output logic                         AVS_WAITREQUEST,
    // analog front end
    input  wire logic                    COMP_IN,
    output adc_seq_pkg::analog_ctrl_s    ANALOG_CTRL,
    // interrupt
    output logic                         IRQ
);
    localparam int RW = adc_seq_pkg::RESULT_WIDTH;
    localparam int CH = adc_seq_pkg::CH_WIDTH;
    localparam int HW = adc_seq_pkg::RES_HIGH_WIDTH;
    localparam int LW = adc_seq_pkg::RES_LOW_WIDTH;

    // ==========================================================
    // state
    logic                 wait_reg;
    logic [31:0]          rdata_reg;
    logic                 time_sel_reg;
    logic [CH-1:0]        chan_sel_reg;
    logic                 start_flag_reg;
    logic [HW-1:0]        res_high_reg;
    logic [LW-1:0]        res_low_reg;
    logic                 done_flag_reg;
    logic                 irq_en_reg;
    logic                 clk_run_reg;
    logic                 irq_reg;
    logic                 chan_en_reg;
    logic [1:0]           chan_reg;

    logic                 wr_fire;
    logic                 rd_take;
    logic [7:0]           wbyte;
    logic                 standby;
    logic                 wr_mode;
    logic                 wr_start;
    logic                 wr_clear;
    logic                 wr_enable;
    logic                 wr_clk;
    logic [7:0]           read_mux;

    logic                 eng_start;
    logic                 eng_abort;
    logic                 eng_sample;
    logic [RW-1:0]        eng_code;
    logic [RW-1:0]        eng_result;
    logic                 eng_done;
    logic                 eng_busy;

    // ==========================================================
    // bus decode
    assign wr_fire   = AVS_REQ.write && !wait_reg &&
                       AVS_REQ.byteenable[0];
    assign rd_take   = AVS_REQ.read && wait_reg;
    assign wbyte     = AVS_REQ.writedata[7:0];
    assign standby   = LOW_POWER || !clk_run_reg;
    assign wr_mode   = wr_fire && AVS_REQ.address == adc_seq_pkg::OFF_MODE;
    assign wr_start  = wr_fire &&
                       AVS_REQ.address == adc_seq_pkg::OFF_START;
    assign wr_clear  = wr_fire &&
                       AVS_REQ.address == adc_seq_pkg::OFF_IRQ_CLEAR;
    assign wr_enable = wr_fire &&
                       AVS_REQ.address == adc_seq_pkg::OFF_IRQ_ENABLE;
    assign wr_clk    = wr_fire &&
                       AVS_REQ.address == adc_seq_pkg::OFF_CLK_STOP;

    always_comb begin
        read_mux = 8'h00;
        unique case (AVS_REQ.address)
            adc_seq_pkg::OFF_MODE:
                read_mux = adc_seq_pkg::MODE_FIXED_ONES |
                           {time_sel_reg, 3'h0, chan_sel_reg};
            adc_seq_pkg::OFF_START:
                read_mux = {start_flag_reg, adc_seq_pkg::START_FIXED_ONES};
            adc_seq_pkg::OFF_RES_HIGH:
                read_mux = res_high_reg;
            adc_seq_pkg::OFF_RES_LOW:
                read_mux = {res_low_reg,
                            {adc_seq_pkg::RES_LOW_SHIFT{1'b0}}};
            adc_seq_pkg::OFF_IRQ_STATUS:
                read_mux = {7'h00, done_flag_reg};
            adc_seq_pkg::OFF_IRQ_ENABLE:
                read_mux = {7'h00, irq_en_reg};
            adc_seq_pkg::OFF_CLK_STOP:
                read_mux = {7'h00, clk_run_reg};
            default:
                read_mux = 8'h00;
        endcase
    end

    // ==========================================================
    // bus handshake: one wait cycle per access
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((AVS_REQ.read || AVS_REQ.write) && wait_reg);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_reg <= {24'h00_0000, read_mux};
        end
    end

    // ==========================================================
    // mode register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            time_sel_reg <= 1'b0;
            chan_sel_reg <= '0;
        end else if (SOFT_RESET) begin
            time_sel_reg <= 1'b0;
            chan_sel_reg <= '0;
        end else if (wr_mode && !standby) begin
            time_sel_reg <= wbyte[adc_seq_pkg::MODE_TIME_BIT];
            chan_sel_reg <= wbyte[CH-1:0];
        end
    end

    // ==========================================================
    // start flag
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            start_flag_reg <= 1'b0;
        end else if (SOFT_RESET || standby) begin
            start_flag_reg <= 1'b0;
        end else if (wr_start) begin
            start_flag_reg <= wbyte[adc_seq_pkg::START_FLAG_BIT];
        end else if (eng_done) begin
            start_flag_reg <= 1'b0;
        end
    end

    assign eng_start = start_flag_reg && !eng_busy && !eng_done;
    assign eng_abort = !start_flag_reg;

    // ==========================================================
    // result pair, kept across soft reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            res_high_reg <= '0;
            res_low_reg  <= '0;
        end else if (eng_done) begin
            res_high_reg <= eng_result[RW-1:LW];
            res_low_reg  <= eng_result[LW-1:0];
        end
    end

    // ==========================================================
    // interrupt status, enable, output
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            done_flag_reg <= 1'b0;
        end else if (SOFT_RESET) begin
            done_flag_reg <= 1'b0;
        end else if (eng_done) begin
            done_flag_reg <= 1'b1;
        end else if (wr_clear && wbyte[adc_seq_pkg::DONE_BIT]) begin
            done_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_en_reg <= 1'b0;
        end else if (SOFT_RESET) begin
            irq_en_reg <= 1'b0;
        end else if (wr_enable) begin
            irq_en_reg <= wbyte[adc_seq_pkg::DONE_BIT];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= done_flag_reg && irq_en_reg;
        end
    end

    // ==========================================================
    // converter clock stop
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_run_reg <= adc_seq_pkg::CLK_RUN_RESET;
        end else if (SOFT_RESET) begin
            clk_run_reg <= adc_seq_pkg::CLK_RUN_RESET;
        end else if (wr_clk) begin
            clk_run_reg <= wbyte[adc_seq_pkg::CLK_RUN_BIT];
        end
    end

    // ==========================================================
    // channel multiplexer select
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            chan_en_reg <= 1'b0;
            chan_reg    <= 2'h0;
        end else begin
            chan_en_reg <= chan_sel_reg[CH-1:2] ==
                           adc_seq_pkg::CH_ACTIVE_PREFIX;
            chan_reg    <= chan_sel_reg[1:0];
        end
    end

    // ==========================================================
    // conversion engine
    sar_engine #(
        .WIDTH      (RW)
    ) u_engine (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .start      (eng_start),
        .abort      (eng_abort),
        .long_mode  (!time_sel_reg),
        .comp       (COMP_IN),
        .sample_reg (eng_sample),
        .code_reg   (eng_code),
        .result_reg (eng_result),
        .done_reg   (eng_done),
        .busy       (eng_busy)
    );

    assign AVS_WAITREQUEST     = wait_reg;
    assign AVS_READDATA        = rdata_reg;
    assign IRQ                 = irq_reg;
    assign ANALOG_CTRL.sample  = eng_sample;
    assign ANALOG_CTRL.chan_en = chan_en_reg;
    assign ANALOG_CTRL.chan    = chan_reg;
    assign ANALOG_CTRL.trial   = eng_code;

    // ==========================================================
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_result_stored;
        eng_done |=> {res_high_reg, res_low_reg} == $past(eng_result);
    endproperty
    a_result_stored: assert property (p_result_stored)
        else $error("result not stored on completion");

    property p_done_sets_flag;
        eng_done && !SOFT_RESET |=>
            done_flag_reg ##1 IRQ == $past(irq_en_reg);
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag)
        else $error("done flag or interrupt wrong after completion");

    property p_start_auto_clear;
        eng_done && !wr_start |=> !start_flag_reg;
    endproperty
    a_start_auto_clear: assert property (p_start_auto_clear)
        else $error("start flag not cleared at end");

    property p_busy_flag_high;
        eng_busy && !start_flag_reg |->
            $past(wr_start || SOFT_RESET || standby);
    endproperty
    a_busy_flag_high: assert property (p_busy_flag_high)
        else $error("start flag low during conversion");

    property p_standby_clears;
        standby |=> !start_flag_reg ##1 !eng_busy;
    endproperty
    a_standby_clears: assert property (p_standby_clears)
        else $error("low power did not stop conversion");

    property p_result_held;
        !eng_done |=> $stable({res_high_reg, res_low_reg});
    endproperty
    a_result_held: assert property (p_result_held)
        else $error("result changed without completion");

    property p_abort;
        wr_start && !wbyte[adc_seq_pkg::START_FLAG_BIT] |=>
            ##1 !eng_busy && !eng_done;
    endproperty
    a_abort: assert property (p_abort)
        else $error("write of 0 did not abort conversion");

    property p_chan_decode;
        ##1 ANALOG_CTRL.chan_en ==
            ($past(chan_sel_reg) == 4'h4 || $past(chan_sel_reg) == 4'h5 ||
             $past(chan_sel_reg) == 4'h6 || $past(chan_sel_reg) == 4'h7);
    endproperty
    a_chan_decode: assert property (p_chan_decode)
        else $error("channel enable decode wrong");

    property p_flag_sticky;
        done_flag_reg && !(wr_clear && wbyte[adc_seq_pkg::DONE_BIT]) &&
            !SOFT_RESET |=> done_flag_reg ##1 IRQ == $past(irq_en_reg);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("done flag or interrupt dropped early");

    property p_start_write;
        wr_start && wbyte[adc_seq_pkg::START_FLAG_BIT] && !standby &&
            !SOFT_RESET |=> start_flag_reg;
    endproperty
    a_start_write: assert property (p_start_write)
        else $error("start write did not set the flag");

    property p_idle_after_done;
        eng_done |-> !eng_busy && !ANALOG_CTRL.sample;
    endproperty
    a_idle_after_done: assert property (p_idle_after_done)
        else $error("engine not idle after completion");

    property p_mode_kept;
        LOW_POWER && !SOFT_RESET |=> $stable({time_sel_reg, chan_sel_reg});
    endproperty
    a_mode_kept: assert property (p_mode_kept)
        else $error("mode changed in low power");

    property p_clear_flag;
        wr_clear && wbyte[adc_seq_pkg::DONE_BIT] && !eng_done |=>
            !done_flag_reg;
    endproperty
    a_clear_flag: assert property (p_clear_flag)
        else $error("done flag not cleared by software");

endmodule : adc_conversion_sequencer

// ===== test/analog_model.sv
`timescale 1ns/1ns
module analog_model (
    // front end control
    input  wire adc_seq_pkg::analog_ctrl_s ctrl,
    input  wire logic [3:0][9:0]           level,
    // comparator
    output logic                           comp
);
    // unselected input behaves as grounded, so every trial is dropped
    assign comp = ctrl.chan_en & (level[ctrl.chan] >= ctrl.trial);
endmodule : analog_model

// ===== test/test_adc_conversion_sequencer.sv
`timescale 1ns/1ns
module test_adc_conversion_sequencer;
    logic                      core_clk;
    logic                      rst_n;
    logic                      soft_reset;
    logic                      low_power;
    adc_seq_pkg::avs_req_s     avs_req;
    logic [31:0]               avs_readdata;
    logic                      avs_waitrequest;
    logic                      comp_in;
    adc_seq_pkg::analog_ctrl_s analog_ctrl;
    logic                      irq;
    logic [3:0][9:0]           level;
    logic [31:0]               rdata;
    logic [9:0]                last_res;
    int                        samp_cnt = 0;
    int                        n_fail = 0;
    int                        n_compared = 0;

    adc_conversion_sequencer adc_conversion_sequencer_inst (
        .CORE_CLK(core_clk), .RST_N(rst_n), .SOFT_RESET(soft_reset),
        .LOW_POWER(low_power), .AVS_REQ(avs_req),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .COMP_IN(comp_in), .ANALOG_CTRL(analog_ctrl), .IRQ(irq));
    analog_model analog_model_inst (
        .ctrl(analog_ctrl), .level(level), .comp(comp_in));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // counts sampling cycles of the running conversion
    always @(posedge core_clk) begin
        if (analog_ctrl.sample === 1'b1) begin
            samp_cnt <= samp_cnt + 1;
        end
    end

    // ==========================================================
    // bus and checking helpers
    task automatic stop_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [4:0] addr,
                       input logic [7:0] wd);
        int i;
        avs_req <= '{read: !wr, write: wr, address: addr,
                     byteenable: 4'hF, writedata: {24'h0, wd}};
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        rdata = avs_readdata;
        avs_req <= '0;
        if (avs_waitrequest !== 1'b0) begin
            check(1'b1, 1'b0, "bus answer missing");
            stop_test();
        end
        @(posedge core_clk);
    endtask : bus

    task automatic rd_check(input logic [4:0] addr, input logic [7:0] exp,
                            input string what);
        bus(1'b0, addr, 8'h00);
        check(rdata, {24'h0, exp}, what);
    endtask : rd_check

    // ==========================================================
    // scenarios
    task automatic convert(input logic [7:0] mode, input int n_states,
                           input logic [9:0] exp);
        int i;
        bus(1'b1, adc_seq_pkg::OFF_MODE, mode);
        samp_cnt <= 0;
        bus(1'b1, adc_seq_pkg::OFF_START, 8'h80);
        rd_check(adc_seq_pkg::OFF_START, 8'hFF, "flag while busy");
        check(analog_ctrl.chan_en, mode[3:2] == 2'h1, "chan enable");
        i = 0;
        do begin
            bus(1'b0, adc_seq_pkg::OFF_START, 8'h00);
            i++;
        end while (rdata[7] !== 1'b0 && i < 60);
        check(rdata, 32'h7F, "flag self clear");
        if (rdata[7] !== 1'b0) stop_test();
        rd_check(adc_seq_pkg::OFF_RES_HIGH, exp[9:2], "high");
        rd_check(adc_seq_pkg::OFF_RES_LOW, {exp[1:0], 6'h0}, "low");
        check(samp_cnt, n_states - 10, "sampling length");
        rd_check(adc_seq_pkg::OFF_IRQ_STATUS, 8'h01, "done flag");
        last_res = exp;
    endtask : convert

    task automatic test_irq();
        bus(1'b1, adc_seq_pkg::OFF_IRQ_ENABLE, 8'h01);
        convert(8'h05, 62, level[1]);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b1, "irq raised");
        repeat (20) @(posedge core_clk);
        check(irq, 1'b1, "irq held");
        bus(1'b1, adc_seq_pkg::OFF_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b0, "irq masked");
        rd_check(adc_seq_pkg::OFF_IRQ_STATUS, 8'h01, "flag kept");
        bus(1'b1, adc_seq_pkg::OFF_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b1, "irq unmasked");
        bus(1'b1, adc_seq_pkg::OFF_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b0, "irq cleared");
        rd_check(adc_seq_pkg::OFF_IRQ_STATUS, 8'h00, "flag cleared");
    endtask : test_irq

    task automatic test_abort();
        bus(1'b1, adc_seq_pkg::OFF_IRQ_CLEAR, 8'h01);
        bus(1'b1, adc_seq_pkg::OFF_MODE, 8'h05);
        bus(1'b1, adc_seq_pkg::OFF_START, 8'h80);
        bus(1'b1, adc_seq_pkg::OFF_START, 8'h00);
        repeat (80) @(posedge core_clk);
        rd_check(adc_seq_pkg::OFF_START, 8'h7F, "aborted flag");
        rd_check(adc_seq_pkg::OFF_IRQ_STATUS, 8'h00, "no done");
        rd_check(adc_seq_pkg::OFF_RES_HIGH, last_res[9:2], "no store");
    endtask : test_abort

    task automatic test_power();
        bus(1'b1, adc_seq_pkg::OFF_CLK_STOP, 8'h00);
        bus(1'b1, adc_seq_pkg::OFF_START, 8'h80);
        rd_check(adc_seq_pkg::OFF_START, 8'h7F, "stopped start");
        bus(1'b1, adc_seq_pkg::OFF_CLK_STOP, 8'h01);
        repeat (10) @(posedge core_clk);
        bus(1'b1, adc_seq_pkg::OFF_MODE, 8'h85);
        bus(1'b1, adc_seq_pkg::OFF_START, 8'h80);
        low_power <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd_check(adc_seq_pkg::OFF_START, 8'h7F, "low power start");
        rd_check(adc_seq_pkg::OFF_MODE, 8'hB5, "low power mode");
        rd_check(adc_seq_pkg::OFF_RES_HIGH, last_res[9:2], "lp res");
        low_power <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        @(posedge core_clk);
        rd_check(adc_seq_pkg::OFF_MODE, 8'h30, "soft reset mode");
        rd_check(adc_seq_pkg::OFF_RES_HIGH, last_res[9:2], "sr res");
        rd_check(adc_seq_pkg::OFF_RES_LOW, {last_res[1:0], 6'h0}, "l");
    endtask : test_power

    initial begin
        rst_n = 1'b0;
        soft_reset = 1'b0;
        low_power = 1'b0;
        avs_req = '0;
        last_res = 10'h000;
        level = {10'h3FF, 10'h29E, 10'h2A5, 10'h001};
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd_check(adc_seq_pkg::OFF_MODE, 8'h30, "mode reset");
        rd_check(adc_seq_pkg::OFF_START, 8'h7F, "start reset");
        rd_check(adc_seq_pkg::OFF_RES_HIGH, 8'h00, "result reset");
        test_irq();
        convert(8'h86, 31, level[2]);
        convert(8'h84, 31, level[0]);
        convert(8'h07, 62, level[3]);
        convert(8'h02, 62, 10'h000);
        test_abort();
        convert(8'h85, 31, level[1]);
        test_power();
        stop_test();
    end
endmodule : test_adc_conversion_sequencer
